// *** common/bdt_params.svh ***
// Offsets, field positions, reset values and timer lengths of the bridge discard-timer control
// Summary of operation
// - Bits 15 to 12 read as zero; writes to them are ignored.
// - Bit 11 enables system error on primary discard timeout; cleared at reset.
// - Bit 10 sets when either discard timer expires; zero after reset.
// - Bit 10 stays set until software writes one; writing zero keeps it.
// - An expired timer drops its pending delayed transaction from the queue.
// - Secondary timer length: bit 9 zero gives 2^15 clocks, one gives 2^10.
// - Primary timer length: bit 8 zero gives 2^15 clocks, one gives 2^10.
// - Bit 7 reads zero; fast back-to-back to different targets never issued.
// - Primary system error also needs the command register system error enable.
`ifndef BDT_PARAMS_SVH
`define BDT_PARAMS_SVH

`define BDT_CTRL_OFFSET        8'h3E
`define BDT_CTRL_RESET         16'h0000
`define BDT_BIT_SERR_TO_EN     11
`define BDT_BIT_STATUS         10
`define BDT_BIT_SEC_SHORT      9
`define BDT_BIT_PRI_SHORT      8
`define BDT_BIT_FBB            7
`define BDT_TMR_CW             16
`define BDT_DISCARD_LONG_CLKS  32768
`define BDT_DISCARD_SHORT_CLKS 1024

`endif

// *** common/bdt_pkg.sv ***
// Types shared by the discard timers and the bridge control register
package bdt_pkg;

    typedef enum logic {
        BDT_IDLE,
        BDT_COUNT
    } bdt_tmr_state_type;

    typedef struct packed {
        bdt_tmr_state_type state;
        logic              short_len;
        logic [15:0]       cnt;
        logic              expire;
        logic [15:0]       elapsed;
    } bdt_tmr_reg_type;

    typedef struct packed {
        logic cpl_ready;
        logic retry;
    } bdt_dly_evt_type;

    typedef struct packed {
        logic serr_to_en;
        logic status;
        logic sec_short;
        logic pri_short;
    } bdt_ctrl_type;

    typedef struct packed {
        bdt_ctrl_type ctrl;
        logic [15:0]  rdata;
        logic         rvalid;
        logic         p_serr;
        logic         fbb_en;
    } bdt_top_reg_type;

endpackage : bdt_pkg

// *** rtl/bdt_bridge_control.sv ***
// Bridge control register upper half with primary and secondary discard timers
`timescale 1ns/1ps
`include "bdt_params.svh"

module bdt_bridge_control #(
    parameter int unsigned LONG_CLKS  = `BDT_DISCARD_LONG_CLKS,
    parameter int unsigned SHORT_CLKS = `BDT_DISCARD_SHORT_CLKS
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    // Configuration access
    input  wire logic [7:0]             cfg_addr,
    input  wire logic                   cfg_wr,
    input  wire logic                   cfg_rd,
    input  wire logic [1:0]             cfg_be,
    input  wire logic [15:0]            cfg_wdata,
    output logic      [15:0]            cfg_rdata,
    output logic                        cfg_rvalid,
    // Primary command register system error enable
    input  wire logic                   cmd_serr_en,
    // Delayed transaction events, index 0 primary, 1 secondary
    input  wire bdt_pkg::bdt_dly_evt_type dly_evt [2],
    // Queue drop, system error and capability
    output logic      [1:0]             dly_discard,
    output logic      [1:0]             dly_timer_busy,
    output logic                        p_serr_req,
    output logic                        fbb_en
);

    localparam logic [15:0] CTRL_RST = `BDT_CTRL_RESET;

    bdt_pkg::bdt_top_reg_type r;
    bdt_pkg::bdt_top_reg_type next_r;
    logic [1:0]               tmr_expire;
    logic [1:0]               tmr_short;
    logic                     ctrl_hit;
    logic                     hi_wr;

    function automatic logic [15:0] ctrl_image(input bdt_pkg::bdt_ctrl_type c);
        logic [15:0] v;
        v = 16'h0000;
        v[15:12] = 4'h0;
        v[`BDT_BIT_SERR_TO_EN] = c.serr_to_en;
        v[`BDT_BIT_STATUS]     = c.status;
        v[`BDT_BIT_SEC_SHORT]  = c.sec_short;
        v[`BDT_BIT_PRI_SHORT]  = c.pri_short;
        v[`BDT_BIT_FBB]        = 1'b0;
        return v;
    endfunction : ctrl_image

    assign ctrl_hit     = (cfg_addr == `BDT_CTRL_OFFSET);
    assign hi_wr        = cfg_wr && ctrl_hit && cfg_be[1];
    assign tmr_short[0] = r.ctrl.pri_short;
    assign tmr_short[1] = r.ctrl.sec_short;

    // Primary timer at index 0, secondary at index 1
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_timer
            bdt_discard_timer #(
                .LONG_CLKS  (LONG_CLKS),
                .SHORT_CLKS (SHORT_CLKS)
            ) bdt_discard_timer_i (
                .mclk      (mclk),
                .sys_rst   (sys_rst),
                .start     (dly_evt[gi].cpl_ready),
                .stop      (dly_evt[gi].retry),
                .len_short (tmr_short[gi]),
                .busy      (dly_timer_busy[gi]),
                .expire    (tmr_expire[gi])
            );
        end
    endgenerate

    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        // Only bits 15 to 8 hold writable state, so only the high byte lane matters
        if (hi_wr) begin
            next_r.ctrl.serr_to_en = cfg_wdata[`BDT_BIT_SERR_TO_EN];
            next_r.ctrl.sec_short  = cfg_wdata[`BDT_BIT_SEC_SHORT];
            next_r.ctrl.pri_short  = cfg_wdata[`BDT_BIT_PRI_SHORT];
            if (cfg_wdata[`BDT_BIT_STATUS]) begin
                next_r.ctrl.status = 1'b0;
            end
        end
        if (|tmr_expire) begin
            next_r.ctrl.status = 1'b1;
        end
        next_r.p_serr = tmr_expire[0] & r.ctrl.serr_to_en & cmd_serr_en;
        next_r.fbb_en = 1'b0;
        if (cfg_rd) begin
            next_r.rvalid = 1'b1;
            next_r.rdata  = ctrl_hit ? ctrl_image(r.ctrl) : 16'h0000;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            r.ctrl.serr_to_en <= CTRL_RST[`BDT_BIT_SERR_TO_EN];
            r.ctrl.status     <= CTRL_RST[`BDT_BIT_STATUS];
            r.ctrl.sec_short  <= CTRL_RST[`BDT_BIT_SEC_SHORT];
            r.ctrl.pri_short  <= CTRL_RST[`BDT_BIT_PRI_SHORT];
            r.rdata           <= 16'h0000;
            r.rvalid          <= 1'b0;
            r.p_serr          <= 1'b0;
            r.fbb_en          <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign cfg_rdata   = r.rdata;
    assign cfg_rvalid  = r.rvalid;
    assign dly_discard = tmr_expire;
    assign p_serr_req  = r.p_serr;
    assign fbb_en      = r.fbb_en;

    chk_reserved_zero: assert property (
        @(posedge mclk) disable iff (sys_rst)
        cfg_rvalid |-> cfg_rdata[15:12] == 4'h0)
        else $error("reserved bits read nonzero");

    chk_serr_enable: assert property (
        @(posedge mclk) disable iff (sys_rst)
        p_serr_req |-> $past(tmr_expire[0]) && $past(r.ctrl.serr_to_en))
        else $error("system error without discard timeout enable");

    chk_serr_cmd_gate: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (tmr_expire[0] && r.ctrl.serr_to_en) |=> p_serr_req == $past(cmd_serr_en))
        else $error("system error not gated by command enable");

    chk_status_set: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (|tmr_expire) |=> r.ctrl.status)
        else $error("discard timeout did not set status");

    chk_status_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (r.ctrl.status && !(hi_wr && cfg_wdata[`BDT_BIT_STATUS])) |=> r.ctrl.status)
        else $error("status bit cleared without write of one");

    chk_status_clear: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (hi_wr && cfg_wdata[`BDT_BIT_STATUS] && !(|tmr_expire)) |=> !r.ctrl.status)
        else $error("write of one did not clear status");

    chk_len_write: assert property (
        @(posedge mclk) disable iff (sys_rst)
        hi_wr |=> r.ctrl.sec_short == $past(cfg_wdata[`BDT_BIT_SEC_SHORT])
              && r.ctrl.pri_short == $past(cfg_wdata[`BDT_BIT_PRI_SHORT]))
        else $error("length select bits not written");

    chk_fbb_zero: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !fbb_en && !(cfg_rvalid && cfg_rdata[`BDT_BIT_FBB]))
        else $error("fast back-to-back shown as enabled");

    chk_read_image: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (cfg_rd && ctrl_hit) |=> cfg_rvalid
            && cfg_rdata[`BDT_BIT_STATUS] == $past(r.ctrl.status))
        else $error("read data does not show status");

    generate
        for (gi = 0; gi < 2; gi++) begin : g_chk_side
            chk_drop_idle: assert property (
                @(posedge mclk) disable iff (sys_rst)
                dly_discard[gi] |-> !dly_timer_busy[gi])
                else $error("discard pulse while timer still busy");
        end
    endgenerate

    chk_sec_no_serr: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (tmr_expire[1] && !tmr_expire[0]) |=> !p_serr_req)
        else $error("secondary timeout raised primary system error");

    chk_serr_single: assert property (
        @(posedge mclk) disable iff (sys_rst)
        p_serr_req |=> !p_serr_req)
        else $error("system error request longer than one cycle");

    chk_status_cause: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (!r.ctrl.status && !(|tmr_expire)) |=> !r.ctrl.status)
        else $error("status set without discard timeout");

    chk_len_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !hi_wr |=> $stable(r.ctrl.sec_short) && $stable(r.ctrl.pri_short))
        else $error("length select changed without write");

    chk_enable_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !hi_wr |=> $stable(r.ctrl.serr_to_en))
        else $error("discard error enable changed without write");

    chk_unmapped_zero: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (cfg_rd && !ctrl_hit) |=> cfg_rvalid && cfg_rdata == 16'h0000)
        else $error("unmapped read returned nonzero data");

    cov_short_expire: cover property (
        @(posedge mclk) disable iff (sys_rst) tmr_expire[0] && r.ctrl.pri_short);
    cov_sec_expire: cover property (
        @(posedge mclk) disable iff (sys_rst) tmr_expire[1]);
    cov_serr: cover property (
        @(posedge mclk) disable iff (sys_rst) p_serr_req);
    cov_set_clear_same: cover property (
        @(posedge mclk) disable iff (sys_rst)
        hi_wr && cfg_wdata[`BDT_BIT_STATUS] && (|tmr_expire));
    cov_retry_stop: cover property (
        @(posedge mclk) disable iff (sys_rst) dly_evt[0].retry && dly_timer_busy[0]);

endmodule : bdt_bridge_control

// *** rtl/bdt_discard_timer.sv ***
// One delayed-transaction discard timer with selectable length
`timescale 1ns/1ps
`include "bdt_params.svh"

module bdt_discard_timer #(
    parameter int unsigned LONG_CLKS  = `BDT_DISCARD_LONG_CLKS,
    parameter int unsigned SHORT_CLKS = `BDT_DISCARD_SHORT_CLKS
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Delayed transaction events
    input  wire logic start,
    input  wire logic stop,
    input  wire logic len_short,
    // Timer state
    output logic      busy,
    output logic      expire
);

    localparam logic [15:0] LONG_LAST  = 16'(LONG_CLKS - 1);
    localparam logic [15:0] SHORT_LAST = 16'(SHORT_CLKS - 1);
    localparam logic [15:0] LONG_LEN   = 16'(LONG_CLKS);
    localparam logic [15:0] SHORT_LEN  = 16'(SHORT_CLKS);

    bdt_pkg::bdt_tmr_reg_type r;
    bdt_pkg::bdt_tmr_reg_type next_r;

    always_comb begin
        next_r = r;
        next_r.expire = 1'b0;
        // Elapsed cycles since start, kept only for checking the length
        if (r.state == bdt_pkg::BDT_IDLE && start) begin
            // Zero at the start edge, so it equals the length on the drop pulse
            next_r.elapsed = 16'h0000;
        end else if (r.elapsed != 16'hFFFF) begin
            next_r.elapsed = r.elapsed + 16'h0001;
        end
        case (r.state)
            bdt_pkg::BDT_IDLE: begin
                if (start) begin
                    next_r.state     = bdt_pkg::BDT_COUNT;
                    next_r.cnt       = 16'h0000;
                    next_r.short_len = len_short;
                end
            end
            bdt_pkg::BDT_COUNT: begin
                if (stop) begin
                    next_r.state = bdt_pkg::BDT_IDLE;
                end else if (r.cnt == (r.short_len ? SHORT_LAST : LONG_LAST)) begin
                    next_r.expire = 1'b1;
                    next_r.state  = bdt_pkg::BDT_IDLE;
                end else begin
                    next_r.cnt = r.cnt + 16'h0001;
                end
            end
            default: begin
                next_r.state = bdt_pkg::BDT_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '{state: bdt_pkg::BDT_IDLE, short_len: 1'b0, cnt: 16'h0000,
                   expire: 1'b0, elapsed: 16'h0000};
        end else begin
            r <= next_r;
        end
    end

    assign busy   = (r.state == bdt_pkg::BDT_COUNT);
    assign expire = r.expire;

    chk_expire_length: assert property (
        @(posedge mclk) disable iff (sys_rst)
        r.expire |-> r.elapsed == (r.short_len ? SHORT_LEN : LONG_LEN))
        else $error("discard timer expired after wrong number of clocks");

    chk_retry_stops: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (r.state == bdt_pkg::BDT_COUNT && stop) |=> !r.expire && r.state == bdt_pkg::BDT_IDLE)
        else $error("retry did not stop the discard timer");

    chk_expire_cause: assert property (
        @(posedge mclk) disable iff (sys_rst)
        r.expire |-> $past(r.state) == bdt_pkg::BDT_COUNT && !$past(stop))
        else $error("discard pulse without a running timer");

endmodule : bdt_discard_timer

// *** test/bdt_pci_master.sv ***
// Behavioural model of the primary and secondary PCI masters issuing delayed requests
`timescale 1ns/1ps

module bdt_pci_master (
    // Clock
    input  wire logic                mclk,
    // Delayed transaction events, index 0 primary, 1 secondary
    output bdt_pkg::bdt_dly_evt_type evt [2]
);
    initial begin
        evt[0] = '0;
        evt[1] = '0;
    end

    task automatic signal_ready(input int side);
        @(negedge mclk);
        evt[side].cpl_ready = 1'b1;
        @(negedge mclk);
        evt[side].cpl_ready = 1'b0;
    endtask : signal_ready

    task automatic retry_request(input int side);
        @(negedge mclk);
        evt[side].retry = 1'b1;
        @(negedge mclk);
        evt[side].retry = 1'b0;
    endtask : retry_request
endmodule : bdt_pci_master

// *** test/bridge_discard_timer_control_tb_top.sv ***
// Self-checking bench of the bridge control register and its discard timers
`timescale 1ns/1ps

module bridge_discard_timer_control_tb_top;
    // Shortened lengths keep the run brief
    localparam int LONG  = 64;
    localparam int SHORT = 16;
    logic                     mclk        = 1'b0;
    logic                     sys_rst     = 1'b1;
    logic [7:0]               cfg_addr    = 8'h00;
    logic                     cfg_wr      = 1'b0;
    logic                     cfg_rd      = 1'b0;
    logic [1:0]               cfg_be      = 2'h0;
    logic [15:0]              cfg_wdata   = 16'h0000;
    logic                     cmd_serr_en = 1'b0;
    logic [15:0]              cfg_rdata;
    logic                     cfg_rvalid;
    bdt_pkg::bdt_dly_evt_type dly_evt [2];
    logic [1:0]               dly_discard;
    logic [1:0]               dly_timer_busy;
    logic                     p_serr_req;
    logic                     fbb_en;
    int                       errors      = 0;
    int                       compares    = 0;

    always #4 mclk = ~mclk;

    bdt_bridge_control #(.LONG_CLKS(LONG), .SHORT_CLKS(SHORT)) bdt_bridge_control_i (
        .mclk(mclk), .sys_rst(sys_rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .cmd_serr_en(cmd_serr_en), .dly_evt(dly_evt),
        .dly_discard(dly_discard), .dly_timer_busy(dly_timer_busy),
        .p_serr_req(p_serr_req), .fbb_en(fbb_en));

    bdt_pci_master bdt_pci_master_i (.mclk(mclk), .evt(dly_evt));

    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t ns: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge mclk);
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge mclk);
        cfg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge mclk);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge mclk);
        cfg_rd = 1'b0;
        check({15'h0000, cfg_rvalid}, 16'h0001, "read valid");
        check(cfg_rdata, exp, "read data");
    endtask : rd

    // Counts edges from the start edge to the drop pulse, then checks error and status
    task automatic run(input int side, input int len, input logic serr, input logic [15:0] r);
        int n;
        n = 0;
        bdt_pci_master_i.signal_ready(side);
        check({15'h0000, dly_timer_busy[side]}, 16'h0001, "busy");
        while (dly_discard[side] !== 1'b1) begin
            @(negedge mclk);
            n++;
            if (n > LONG + 8) begin
                errors++;
                $display("unexpected at %0t ns: no discard", $time);
                final_report();
            end
        end
        check(16'(n), 16'(len), "discard delay");
        check({15'h0000, dly_timer_busy[side]}, 16'h0000, "busy after expiry");
        @(negedge mclk);
        check({15'h0000, p_serr_req}, {15'h0000, serr}, "system error");
        rd(8'h3E, r);
    endtask : run

    task automatic t_regs();
        rd(8'h3E, 16'h0000);
        rd(8'h3C, 16'h0000);
        wr(8'h3E, 2'b11, 16'hFFFF);
        rd(8'h3E, 16'h0B00);
        wr(8'h3E, 2'b01, 16'h0000);
        wr(8'h3C, 2'b11, 16'h0000);
        rd(8'h3E, 16'h0B00);
        check({15'h0000, fbb_en}, 16'h0000, "fast back-to-back");
        wr(8'h3E, 2'b10, 16'h0000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_sec_short();
        wr(8'h3E, 2'b10, 16'h0200);
        run(1, SHORT, 1'b0, 16'h0600);
        $display("test secondary short done");
    endtask : t_sec_short

    task automatic t_status_w1c();
        wr(8'h3E, 2'b10, 16'h0200);
        rd(8'h3E, 16'h0600);
        wr(8'h3E, 2'b10, 16'h0600);
        rd(8'h3E, 16'h0200);
        $display("test status clear done");
    endtask : t_status_w1c

    task automatic t_pri_long();
        cmd_serr_en = 1'b1;
        wr(8'h3E, 2'b10, 16'h0800);
        run(0, LONG, 1'b1, 16'h0C00);
        wr(8'h3E, 2'b10, 16'h0C00);
        // Secondary timeouts never reach the primary error line
        run(1, LONG, 1'b0, 16'h0C00);
        $display("test primary long done");
    endtask : t_pri_long

    task automatic t_serr_gate();
        cmd_serr_en = 1'b0;
        wr(8'h3E, 2'b10, 16'h0D00);
        run(0, SHORT, 1'b0, 16'h0D00);
        cmd_serr_en = 1'b1;
        wr(8'h3E, 2'b10, 16'h0500);
        run(0, SHORT, 1'b0, 16'h0500);
        $display("test error gating done");
    endtask : t_serr_gate

    task automatic t_retry();
        logic seen;
        seen = 1'b0;
        wr(8'h3E, 2'b10, 16'h0500);
        bdt_pci_master_i.signal_ready(0);
        repeat (5) @(negedge mclk);
        bdt_pci_master_i.retry_request(0);
        check({15'h0000, dly_timer_busy[0]}, 16'h0000, "busy after retry");
        repeat (SHORT + 4) begin
            @(negedge mclk);
            seen = seen | dly_discard[0];
        end
        check({15'h0000, seen}, 16'h0000, "discard after retry");
        rd(8'h3E, 16'h0100);
        $display("test retry done");
    endtask : t_retry

    // Retry taken on the very edge the count ends must still win
    task automatic t_late_retry();
        logic seen;
        seen = 1'b0;
        wr(8'h3E, 2'b10, 16'h0100);
        bdt_pci_master_i.signal_ready(0);
        repeat (SHORT - 2) @(negedge mclk);
        bdt_pci_master_i.retry_request(0);
        seen = dly_discard[0];
        repeat (SHORT) begin
            @(negedge mclk);
            seen = seen | dly_discard[0];
        end
        check({15'h0000, seen}, 16'h0000, "discard after last-cycle retry");
        rd(8'h3E, 16'h0100);
        $display("test late retry done");
    endtask : t_late_retry

    initial begin
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        t_regs();
        t_sec_short();
        t_status_w1c();
        t_pri_long();
        t_serr_gate();
        t_retry();
        t_late_retry();
        final_report();
    end
endmodule : bridge_discard_timer_control_tb_top
